// ---- hw/ssc_top.sv ----
// Clocked-synchronous transmit and receive path of the serial communication unit
`timescale 1ns/10ps
module ssc_top
	import ssc_pkg::*;
#(
	parameter int unsigned HALF_CYC  = SCK_HALF_CYC,
	parameter int unsigned BUF_DEPTH = TX_BUF_DEPTH
) (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	// Control bits
	input  wire logic       tx_enable_in,
	input  wire logic       rx_enable_in,
	input  wire logic       clk_source_sel_in,
	input  wire logic       tx_empty_irq_en_in,
	input  wire logic       tx_end_irq_en_in,
	input  wire logic       rx_irq_en_in,
	// Software access
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_data_wr_in,
	input  wire logic       tx_empty_clr_in,
	input  wire logic       rx_full_clr_in,
	input  wire logic       overrun_clr_in,
	input  wire logic       frame_err_clr_in,
	input  wire logic       parity_err_clr_in,
	input  wire logic       frame_err_set_in,
	input  wire logic       parity_err_set_in,
	// Transfer-request engine access
	input  wire logic       dma_tx_valid_in,
	input  wire logic [7:0] dma_tx_data_in,
	output logic            dma_tx_ready_out,
	input  wire logic       dma_rx_rd_in,
	// Status
	output logic            tx_empty_flag_out,
	output logic            tx_done_flag_out,
	output logic            rx_full_flag_out,
	output logic            overrun_flag_out,
	output logic            frame_err_flag_out,
	output logic            parity_err_flag_out,
	output logic      [7:0] rx_data_out,
	output logic            tx_empty_irq_out,
	output logic            tx_end_irq_out,
	output logic            rx_full_irq_out,
	output logic            rx_error_irq_out,
	// Serial pins
	output logic            txd_out,
	input  wire logic       rxd_in,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe_out
);
	localparam logic [4:0] BURST_LOAD = 5'(RX_ONLY_PULSES);

	// ==========================================================
	// State
	// ==========================================================
	ssc_tx_state_e tx_state, next_tx_state;
	logic [7:0]    tx_data_reg, next_tx_data_reg;
	logic [7:0]    tx_shift_reg, next_tx_shift_reg;
	logic [2:0]    tx_cnt, next_tx_cnt;
	logic          tx_empty_flag, next_tx_empty_flag;
	logic          tx_done_flag, next_tx_done_flag;
	logic          next_txd, next_sck;
	logic [7:0]    rx_shift_reg, next_rx_shift_reg;
	logic [7:0]    rx_data_reg, next_rx_data_reg;
	logic [2:0]    rx_cnt, next_rx_cnt;
	logic          rx_full_flag, next_rx_full_flag;
	logic          overrun_flag, next_overrun_flag;
	logic          frame_err_flag, next_frame_err_flag;
	logic          parity_err_flag, next_parity_err_flag;
	logic [4:0]    rx_burst, next_rx_burst;

	// Synchronisers and edge finding
	logic          sck_s1, sck_s2, sck_s3;
	logic          rxd_s1, rxd_s2;
	logic          ext_clk, tick, div_run;
	logic          sck_rise, sck_fall, any_err, rx_go;
	logic          buf_valid, buf_take;
	logic [7:0]    buf_data;

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	// The first stage feeds only the second; edges are found between stages two and three
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			sck_s1 <= SCK_IDLE_LVL;
			sck_s2 <= SCK_IDLE_LVL;
			sck_s3 <= SCK_IDLE_LVL;
			rxd_s1 <= 1'h1;
			rxd_s2 <= 1'h1;
		end else begin
			sck_s1 <= sck_in;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			rxd_s1 <= rxd_in;
			rxd_s2 <= rxd_s1;
		end
	end

	// ==========================================================
	// Serial clock source
	// ==========================================================
	assign ext_clk = clk_source_sel_in;

	// Keep the divider running until the clock is back high so no runt pulse is left
	assign div_run = !ext_clk &&
		((tx_state != SSC_TX_IDLE) || (rx_burst != 5'h00) || !sck_out);

	ssc_clk_div #(
		.HALF_CYC (HALF_CYC)
	) u_div (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.run_in     (div_run),
		.tick_out   (tick)
	);

	// Internal edges are decided from our own registered clock; external from the synchroniser
	assign sck_fall = ext_clk ? (!sck_s2 && sck_s3) : (tick && sck_out);
	assign sck_rise = ext_clk ? (sck_s2 && !sck_s3) : (tick && !sck_out);

	// ==========================================================
	// Transmit request buffer
	// ==========================================================
	// Software writes take priority; the buffer waits until the data register is free
	assign buf_take = tx_enable_in && tx_empty_flag && !tx_data_wr_in;

	ssc_buf2 #(
		.WIDTH (CHAR_BITS),
		.DEPTH (BUF_DEPTH)
	) u_txbuf (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (dma_tx_valid_in),
		.in_data_in    (dma_tx_data_in),
		.in_ready_out  (dma_tx_ready_out),
		.out_valid_out (buf_valid),
		.out_data_out  (buf_data),
		.out_ready_in  (buf_take)
	);

	// ==========================================================
	// Next-state logic
	// ==========================================================
	assign any_err = overrun_flag || frame_err_flag || parity_err_flag;
	assign rx_go   = rx_enable_in && !any_err;

	always_comb begin
		next_tx_state        = tx_state;
		next_tx_data_reg     = tx_data_reg;
		next_tx_shift_reg    = tx_shift_reg;
		next_tx_cnt          = tx_cnt;
		next_tx_empty_flag   = tx_empty_flag;
		next_tx_done_flag    = tx_done_flag;
		next_txd             = txd_out;
		next_rx_shift_reg    = rx_shift_reg;
		next_rx_data_reg     = rx_data_reg;
		next_rx_cnt          = rx_cnt;
		next_rx_full_flag    = rx_full_flag;
		next_overrun_flag    = overrun_flag;
		next_frame_err_flag  = frame_err_flag;
		next_parity_err_flag = parity_err_flag;
		next_rx_burst        = rx_burst;
		next_sck             = sck_out;

		// Clears come first so that a hardware set later in this block wins
		if (tx_empty_clr_in) begin
			next_tx_empty_flag = 1'h0;
		end
		if (rx_full_clr_in || dma_rx_rd_in) begin
			next_rx_full_flag = 1'h0;
		end
		if (overrun_clr_in) begin
			next_overrun_flag = 1'h0;
		end
		if (frame_err_clr_in) begin
			next_frame_err_flag = 1'h0;
		end
		if (parity_err_clr_in) begin
			next_parity_err_flag = 1'h0;
		end
		if (frame_err_set_in) begin
			next_frame_err_flag = 1'h1;
		end
		if (parity_err_set_in) begin
			next_parity_err_flag = 1'h1;
		end

		// A buffered write lands only on an empty register, so it checks and clears in one go
		if (tx_data_wr_in) begin
			next_tx_data_reg = tx_data_in;
		end else if (buf_valid && buf_take) begin
			next_tx_data_reg   = buf_data;
			next_tx_empty_flag = 1'h0;
		end

		// Transmitter
		unique case (tx_state)
			SSC_TX_IDLE: begin
				if (tx_enable_in && !tx_empty_flag && !any_err) begin
					next_tx_shift_reg  = tx_data_reg;
					next_tx_empty_flag = 1'h1;
					next_tx_done_flag  = 1'h0;
					next_tx_cnt        = 3'h0;
					next_tx_state      = SSC_TX_SHIFT;
				end
			end
			SSC_TX_SHIFT: begin
				if (sck_fall) begin
					next_txd          = tx_shift_reg[0];
					next_tx_shift_reg = {1'h0, tx_shift_reg[7:1]};
					next_tx_cnt       = 3'(tx_cnt + 1'h1);
					if (tx_cnt == LAST_BIT_IDX) begin
						if (!tx_empty_flag && !any_err) begin
							// Chain without a gap: next falling edge drives bit 0
							next_tx_shift_reg  = tx_data_reg;
							next_tx_empty_flag = 1'h1;
							next_tx_cnt        = 3'h0;
						end else begin
							next_tx_done_flag = 1'h1;
							next_tx_state     = SSC_TX_LAST;
						end
					end
				end
			end
			SSC_TX_LAST: begin
				// The partner still needs the rising edge of the last bit; txd keeps its level
				if (sck_rise) begin
					next_tx_state = SSC_TX_IDLE;
				end
			end
		endcase

		if (!tx_enable_in) begin
			next_tx_state      = SSC_TX_IDLE;
			next_tx_shift_reg  = DATA_RESET;
			next_tx_cnt        = 3'h0;
			next_tx_empty_flag = 1'h1;
			next_tx_done_flag  = 1'h1;
		end

		// Receive-only bursts of two characters with the internal clock
		if (!ext_clk && rx_go && !tx_enable_in && rx_burst == 5'h00 && !rx_full_flag) begin
			next_rx_burst = BURST_LOAD;
		end else if (!ext_clk && sck_rise && rx_burst != 5'h00) begin
			next_rx_burst = 5'(rx_burst - 1'h1);
		end

		// Receiver: the receive data and flags are untouched by a disable
		if (!rx_go) begin
			next_rx_cnt = 3'h0;
		end else if (sck_rise) begin
			next_rx_shift_reg[rx_cnt] = rxd_s2;
			next_rx_cnt = 3'(rx_cnt + 1'h1);
			if (rx_cnt == LAST_BIT_IDX) begin
				if (!rx_full_flag) begin
					next_rx_data_reg  = {rxd_s2, rx_shift_reg[6:0]};
					next_rx_full_flag = 1'h1;
				end else begin
					next_overrun_flag = 1'h1;
				end
			end
		end

		// Serial clock pin level; idles high between characters
		if (ext_clk) begin
			next_sck = SCK_IDLE_LVL;
		end else if (tick) begin
			next_sck = !sck_out;
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			tx_state        <= SSC_TX_IDLE;
			tx_data_reg     <= DATA_RESET;
			tx_shift_reg    <= DATA_RESET;
			tx_cnt          <= 3'h0;
			tx_empty_flag   <= 1'h1;
			tx_done_flag    <= 1'h1;
			txd_out         <= TXD_RESET_LVL;
			rx_shift_reg    <= DATA_RESET;
			rx_data_reg     <= DATA_RESET;
			rx_cnt          <= 3'h0;
			rx_full_flag    <= 1'h0;
			overrun_flag    <= 1'h0;
			frame_err_flag  <= 1'h0;
			parity_err_flag <= 1'h0;
			rx_burst        <= 5'h00;
			sck_out         <= SCK_IDLE_LVL;
		end else begin
			tx_state        <= next_tx_state;
			tx_data_reg     <= next_tx_data_reg;
			tx_shift_reg    <= next_tx_shift_reg;
			tx_cnt          <= next_tx_cnt;
			tx_empty_flag   <= next_tx_empty_flag;
			tx_done_flag    <= next_tx_done_flag;
			txd_out         <= next_txd;
			rx_shift_reg    <= next_rx_shift_reg;
			rx_data_reg     <= next_rx_data_reg;
			rx_cnt          <= next_rx_cnt;
			rx_full_flag    <= next_rx_full_flag;
			overrun_flag    <= next_overrun_flag;
			frame_err_flag  <= next_frame_err_flag;
			parity_err_flag <= next_parity_err_flag;
			rx_burst        <= next_rx_burst;
			sck_out         <= next_sck;
		end
	end

	// ==========================================================
	// Status and request outputs
	// ==========================================================
	// Requests are levels built from the next flag value, so they change with the flag and follow the enable one cycle later
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			sck_oe_out       <= 1'h0;
			tx_empty_irq_out <= 1'h0;
			tx_end_irq_out   <= 1'h0;
			rx_full_irq_out  <= 1'h0;
			rx_error_irq_out <= 1'h0;
		end else begin
			sck_oe_out       <= !ext_clk;
			tx_empty_irq_out <= next_tx_empty_flag && tx_empty_irq_en_in && tx_enable_in;
			tx_end_irq_out   <= next_tx_done_flag && tx_end_irq_en_in;
			rx_full_irq_out  <= next_rx_full_flag && rx_irq_en_in;
			rx_error_irq_out <= (next_overrun_flag || next_frame_err_flag ||
				next_parity_err_flag) && rx_irq_en_in;
		end
	end

	assign tx_empty_flag_out   = tx_empty_flag;
	assign tx_done_flag_out    = tx_done_flag;
	assign rx_full_flag_out    = rx_full_flag;
	assign overrun_flag_out    = overrun_flag;
	assign frame_err_flag_out  = frame_err_flag;
	assign parity_err_flag_out = parity_err_flag;
	assign rx_data_out         = rx_data_reg;
endmodule // ssc_top

// ---- hw/ssc_pkg.sv ----
// Shared constants and types for the synchronous serial channel
package ssc_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CLK_PERIOD_NS  = 40;
	localparam int unsigned SCK_HALF_NS    = 160;
	// Least time, so round up to whole cycles
	localparam int unsigned SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Frame format and sizes
	// ==========================================================
	localparam int unsigned CHAR_BITS      = 8;
	localparam int unsigned RX_ONLY_PULSES = 16;
	localparam int unsigned TX_BUF_DEPTH   = 2;
	localparam logic [2:0]  LAST_BIT_IDX   = 3'h7;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0]  DATA_RESET     = 8'h00;
	localparam logic        SCK_IDLE_LVL   = 1'h1;
	localparam logic        TXD_RESET_LVL  = 1'h1;

	// ==========================================================
	// Transmitter states
	// ==========================================================
	typedef enum logic [1:0] {
		SSC_TX_IDLE,
		SSC_TX_SHIFT,
		SSC_TX_LAST
	} ssc_tx_state_e;

endpackage

// ---- hw/ssc_clk_div.sv ----
// Half-period tick divider for the internally generated serial clock
`timescale 1ns/10ps
module ssc_clk_div
	import ssc_pkg::*;
#(
	parameter int unsigned HALF_CYC = SCK_HALF_CYC
) (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic run_in,
	output logic      tick_out
);
	localparam int unsigned CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	localparam logic [CW-1:0] LAST_CNT = CW'(HALF_CYC - 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_tick;

	// Counter restarts whenever the clock is parked so the first edge is a full half period away
	always_comb begin
		next_cnt  = cnt;
		next_tick = 1'h0;
		if (!run_in) begin
			next_cnt = '0;
		end else if (cnt == LAST_CNT) begin
			next_cnt  = '0;
			next_tick = 1'h1;
		end else begin
			next_cnt = CW'(cnt + 1'h1);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			cnt      <= '0;
			tick_out <= 1'h0;
		end else begin
			cnt      <= next_cnt;
			tick_out <= next_tick;
		end
	end
endmodule // ssc_clk_div

// ---- hw/ssc_buf2.sv ----
// Small valid/ready buffer carrying transfer-request writes into the transmit data register
`timescale 1ns/10ps
module ssc_buf2
	import ssc_pkg::*;
#(
	parameter int unsigned WIDTH = CHAR_BITS,
	parameter int unsigned DEPTH = TX_BUF_DEPTH
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb begin
		push        = in_valid_in && in_ready_out;
		pop         = out_valid_out && out_ready_in;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'h1);
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'h1);
		end
		if (push && !pop) begin
			next_count = (PW+1)'(count + 1'h1);
		end else if (pop && !push) begin
			next_count = (PW+1)'(count - 1'h1);
		end
	end

	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			wr_ptr       <= '0;
			rd_ptr       <= '0;
			count        <= '0;
			in_ready_out <= 1'h1;
		end else begin
			wr_ptr       <= next_wr_ptr;
			rd_ptr       <= next_rd_ptr;
			count        <= next_count;
			in_ready_out <= (next_count != FULL_CNT);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
endmodule // ssc_buf2

// ---- dv/ssc_top_props.sv ----
// Port-level checker for the synchronous serial channel
`timescale 1ns/10ps
module ssc_top_props
	import ssc_pkg::*;
#(
	parameter int unsigned HALF_CYC = SCK_HALF_CYC
) (
	input wire logic       ref_clk_in,
	input wire logic       rst_n_in,
	input wire logic       tx_enable_in,
	input wire logic       rx_enable_in,
	input wire logic       clk_source_sel_in,
	input wire logic       rx_irq_en_in,
	input wire logic       tx_end_irq_en_in,
	input wire logic       rx_full_clr_in,
	input wire logic       dma_rx_rd_in,
	input wire logic       tx_empty_flag_out,
	input wire logic       tx_done_flag_out,
	input wire logic       rx_full_flag_out,
	input wire logic       overrun_flag_out,
	input wire logic       frame_err_flag_out,
	input wire logic       parity_err_flag_out,
	input wire logic [7:0] rx_data_out,
	input wire logic       tx_end_irq_out,
	input wire logic       rx_full_irq_out,
	input wire logic       rx_error_irq_out,
	input wire logic       txd_out,
	input wire logic       sck_out,
	input wire logic       sck_oe_out
);
	// ==========================================================
	// Helpers
	// ==========================================================
	localparam int LOAD_MAX = 120;
	int unsigned park_cnt;
	int unsigned next_park_cnt;
	logic        any_err;
	assign any_err = overrun_flag_out | frame_err_flag_out | parity_err_flag_out;
	// Saturates so a long idle never wraps back into the window
	always_comb begin
		next_park_cnt = park_cnt;
		if (!tx_done_flag_out || !tx_enable_in || clk_source_sel_in) next_park_cnt = 0;
		else if (park_cnt < 100) next_park_cnt = park_cnt + 1;
	end
	always_ff @(posedge ref_clk_in) begin
		park_cnt <= rst_n_in ? next_park_cnt : 0;
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence reload_s;
		##[1:LOAD_MAX] tx_empty_flag_out;
	endsequence
	sequence end_irq_s;
		##[0:1] tx_end_irq_out;
	endsequence
	// ==========================================================
	// Properties
	// ==========================================================
	tx_off_a: assert property (!tx_enable_in |=> tx_empty_flag_out && tx_done_flag_out)
		else $error("transmit disable left flags low");
	rx_keep_a: assert property (!rx_enable_in && !rx_full_clr_in && !dma_rx_rd_in
		|=> $stable(rx_data_out) && $stable(rx_full_flag_out)) else $error("rx state moved");
	empty_load_a: assert property ($fell(tx_empty_flag_out) && !any_err && tx_enable_in
		|-> reload_s) else $error("no load after empty cleared");
	full_hold_a: assert property (rx_full_flag_out && !rx_full_clr_in && !dma_rx_rd_in
		|=> rx_full_flag_out && $stable(rx_data_out)) else $error("full data overwritten");
	err_nofill_a: assert property ((frame_err_flag_out || parity_err_flag_out)
		&& !rx_full_flag_out |=> !rx_full_flag_out) else $error("full set under error");
	rx_irq_a: assert property ($rose(rx_full_flag_out) && rx_irq_en_in
		|-> ##[0:1] rx_full_irq_out) else $error("no full irq");
	err_irq_a: assert property ($rose(overrun_flag_out) && rx_irq_en_in
		|-> ##[0:1] rx_error_irq_out) else $error("no error irq");
	end_irq_a: assert property ($rose(tx_done_flag_out) && tx_end_irq_en_in |-> end_irq_s)
		else $error("no end irq");
	txd_hold_a: assert property (tx_done_flag_out && $past(tx_done_flag_out) && tx_enable_in
		&& $past(tx_enable_in) |-> $stable(txd_out)) else $error("txd moved after end");
	oe_sel_a: assert property ($past(rst_n_in)
		|-> sck_oe_out == !$past(clk_source_sel_in)) else $error("clock enable wrong");
	sck_park_a: assert property (park_cnt > 2 * HALF_CYC + 2 |-> sck_out)
		else $error("clock not parked high");
endmodule // ssc_top_props

// ---- dv/ssc_peer.sv ----
// Far-side serial device: clock source in external mode, follower in internal mode
`timescale 1ns/10ps
module ssc_peer (
	input  wire logic ext_in,
	input  wire logic dut_sck_in,
	input  wire logic txd_in,
	output logic      sck_out,
	output logic      rxd_out
);
	logic [31:0] src;
	logic [31:0] got;
	int          idx;
	int          cnt;
	initial begin
		sck_out = 1'h1;
		rxd_out = 1'h1;
		src = '0;
		got = '0;
		idx = 0;
		cnt = 0;
	end
	task automatic arm(input logic [31:0] s);
		src = s;
		got = '0;
		idx = 0;
		cnt = 0;
	endtask
	// ==========================================================
	// External clock: idle high, sample late since the device lags
	// ==========================================================
	task automatic run(input int n);
		for (int i = 0; i < n; i++) begin
			sck_out = 1'h0;
			rxd_out = src[i];
			#160 sck_out = 1'h1;
			#150 got = {txd_in, got[31:1]};
			#10;
		end
		rxd_out = ~rxd_out;
	endtask
	always @(negedge dut_sck_in) if (!ext_in) begin
		rxd_out = src[idx];
		idx++;
	end
	always @(posedge dut_sck_in) if (!ext_in) begin
		got = {txd_in, got[31:1]};
		cnt++;
		// Flip the line after each character so a late sample shows up
		if (cnt % 8 == 0) rxd_out = ~rxd_out;
	end
endmodule // ssc_peer

// ---- dv/ssc_top_tb.sv ----
// Self-checking bench for the synchronous serial channel
`timescale 1ns/10ps
module ssc_top_tb
	import ssc_pkg::*;
;
	typedef struct packed {logic ext; logic [7:0] td; logic [7:0] rd;} ssc_row_s;
	ssc_row_s   rows [4] = '{'{1'h0, 8'hA5, 8'h3C}, '{1'h0, 8'h01, 8'h80},
	                         '{1'h1, 8'h5A, 8'hC3}, '{1'h1, 8'hFF, 8'h00}};
	logic       clk, rst_n, tx_en, rx_en, sel, irq_en, tx_wr, tx_clr, rxf_clr, ovr_clr;
	logic       fe_clr, pe_clr, fe_set, pe_set, dv, rdy, drd, empty, done, full, ovr;
	logic       fe, pe, ei, endi, fi, erri, txd, sck_o, oe, p_sck, p_rxd;
	logic [7:0] tx_d, dma_d, rx_d;
	int         bad_count, n_tests, i;
	ssc_top uut (.ref_clk_in(clk), .rst_n_in(rst_n), .tx_enable_in(tx_en),
		.rx_enable_in(rx_en), .clk_source_sel_in(sel), .tx_empty_irq_en_in(irq_en),
		.tx_end_irq_en_in(irq_en), .rx_irq_en_in(irq_en), .tx_data_in(tx_d),
		.tx_data_wr_in(tx_wr), .tx_empty_clr_in(tx_clr), .rx_full_clr_in(rxf_clr),
		.overrun_clr_in(ovr_clr), .frame_err_clr_in(fe_clr), .parity_err_clr_in(pe_clr),
		.frame_err_set_in(fe_set), .parity_err_set_in(pe_set), .dma_tx_valid_in(dv),
		.dma_tx_data_in(dma_d), .dma_tx_ready_out(rdy), .dma_rx_rd_in(drd),
		.tx_empty_flag_out(empty), .tx_done_flag_out(done), .rx_full_flag_out(full),
		.overrun_flag_out(ovr), .frame_err_flag_out(fe), .parity_err_flag_out(pe),
		.rx_data_out(rx_d), .tx_empty_irq_out(ei), .tx_end_irq_out(endi),
		.rx_full_irq_out(fi), .rx_error_irq_out(erri), .txd_out(txd), .rxd_in(p_rxd),
		.sck_in(p_sck), .sck_out(sck_o), .sck_oe_out(oe));
	ssc_peer peer (.ext_in(sel), .dut_sck_in(sck_o), .txd_in(txd), .sck_out(p_sck),
		.rxd_out(p_rxd));
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic hang(input string nm);
		bad_count++;
		$display("CHECK FAILED %s expected event seen timeout", nm);
		close_out();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
		cyc(1);
	endtask
	// Kind 0 waits for transmit end, kind 1 for receive full
	task automatic wait_for(input int w);
		int k;
		for (k = 0; k < 2000; k++) begin
			if (w == 0 ? (done === 1'h1 && empty === 1'h1) : (full === 1'h1)) break;
			cyc(1);
		end
		if (k == 2000) hang("wait");
	endtask
	task automatic send(input logic [7:0] b);
		tx_d = b;
		pulse(tx_wr);
		pulse(tx_clr);
		cyc(3);
	endtask
	task automatic dma_push(input logic [7:0] b);
		int k;
		dma_d = b;
		dv = 1'h1;
		for (k = 0; k < 400 && rdy !== 1'h1; k++) cyc(1);
		if (k == 400) hang("dma ready");
		cyc(1);
		dv = 1'h0;
		cyc(1);
	endtask
	task automatic mode(input logic ext);
		tx_en = 1'h0;
		rx_en = 1'h0;
		cyc(1);
		sel = ext;
		cyc(1);
		chk("tx off", 2'h3, {empty, done});
		tx_en = 1'h1;
		rx_en = 1'h1;
		cyc(1);
	endtask
	// ==========================================================
	// Sequence
	// ==========================================================
	initial begin
		{tx_en, rx_en, sel, tx_wr, tx_clr, rxf_clr, ovr_clr, fe_clr, pe_clr} = '0;
		{fe_set, pe_set, dv, drd, tx_d, dma_d} = '0;
		irq_en = 1'h1;
		rst_n = 1'h0;
		bad_count = 0;
		n_tests = 0;
		cyc(10);
		rst_n = 1'h1;
		cyc(1);
		chk("reset ones", {TXD_RESET_LVL, SCK_IDLE_LVL, 3'h7}, {txd, sck_o, empty, done, rdy});
		chk("reset zeros", 0, {full, ovr, fe, pe, rx_d, fi, erri});
		chk("reset oe", 1'h1, oe);
		$display("reset test done");
		foreach (rows[r]) begin
			mode(rows[r].ext);
			peer.arm({24'h0, rows[r].rd});
			send(rows[r].td);
			chk("empty reload", 2'h3, {empty, ei});
			if (rows[r].ext) peer.run(8);
			wait_for(0);
			cyc(10);
			chk("tx byte", rows[r].td, peer.got[31:24]);
			chk("end irq", 1'h1, endi);
			if (!rows[r].ext) chk("pulses", 8, peer.cnt);
			wait_for(1);
			chk("rx byte", rows[r].rd, rx_d);
			chk("full irq", 1'h1, fi);
			if (rows[r].ext) pulse(drd);
			else pulse(rxf_clr);
			chk("full clr", 1'h0, full);
			$display("row %0d done", r);
		end
		mode(1'h0);
		peer.arm(32'h0000C381);
		send(8'h96);
		send(8'h69);
		chk("chain pending", 2'h0, {empty, ei});
		wait_for(0);
		cyc(10);
		chk("chain data", 16'h6996, peer.got[31:16]);
		chk("chain pulses", 16, peer.cnt);
		chk("overrun", 3'h7, {full, ovr, erri});
		chk("rx kept", 8'h81, rx_d);
		rx_en = 1'h0;
		cyc(4);
		chk("rx off", {8'h81, 2'h3}, {rx_d, full, ovr});
		rx_en = 1'h1;
		pulse(rxf_clr);
		send(8'h3C);
		cyc(100);
		chk("ovr block", 1'h0, empty);
		pulse(ovr_clr);
		cyc(4);
		wait_for(0);
		cyc(10);
		chk("after ovr", 8'h3C, peer.got[31:24]);
		pulse(rxf_clr);
		$display("chain and overrun test done");
		for (i = 0; i < 2; i++) begin
			peer.arm((i == 0) ? 32'h000000A3 : 32'h0000003A);
			fe_set = (i == 0);
			pe_set = (i == 1);
			cyc(1);
			{fe_set, pe_set} = 2'h0;
			send(8'hC5);
			cyc(80);
			chk("err block", 2'h1, {empty, erri});
			fe_clr = (i == 0);
			pe_clr = (i == 1);
			cyc(1);
			{fe_clr, pe_clr} = 2'h0;
			cyc(4);
			wait_for(0);
			cyc(10);
			chk("err resume", 8'hC5, peer.got[31:24]);
			wait_for(1);
			chk("err rx", (i == 0) ? 8'hA3 : 8'h3A, rx_d);
			pulse(rxf_clr);
		end
		$display("error test done");
		rx_en = 1'h0;
		tx_en = 1'h0;
		peer.arm(0);
		dma_push(8'h11);
		dma_push(8'h22);
		chk("buf refuse", 1'h0, rdy);
		tx_en = 1'h1;
		dma_push(8'h33);
		cyc(4);
		wait_for(0);
		cyc(10);
		chk("dma data", 24'h332211, peer.got[31:8]);
		chk("dma pulses", 24, peer.cnt);
		$display("transfer engine test done");
		peer.arm(32'h0000E71B);
		tx_en = 1'h0;
		rx_en = 1'h1;
		wait_for(1);
		chk("burst byte 1", 8'h1B, rx_d);
		pulse(rxf_clr);
		wait_for(1);
		chk("burst byte 2", 8'hE7, rx_d);
		cyc(40);
		chk("burst pulses", 16, peer.cnt);
		chk("burst no ovr", 1'h0, ovr);
		$display("receive-only test done");
		close_out();
	end
endmodule // ssc_top_tb
bind ssc_top ssc_top_props #(.HALF_CYC(HALF_CYC)) u_props (.*);
